//--- rtl/mtc_defines.vh
`ifndef MTC_DEFINES_VH
`define MTC_DEFINES_VH

// Register byte offsets
`define MTC_OFF_CTRL     8'h00
`define MTC_OFF_COUNT    8'h04
`define MTC_OFF_PERIOD   8'h08
`define MTC_OFF_STATUS   8'h0c
`define MTC_OFF_MASK     8'h10

// Control register fields
`define MTC_CTRL_CLEAR   0
`define MTC_CTRL_MODE_LO 1
`define MTC_CTRL_MODE_HI 2
`define MTC_CTRL_DIV_LO  3
`define MTC_CTRL_DIV_HI  4
`define MTC_CTRL_SRC_LO  5
`define MTC_CTRL_SRC_HI  6
`define MTC_CTRL_LEN_LO  7
`define MTC_CTRL_LEN_HI  8
`define MTC_CTRL_LOAD_LO 9
`define MTC_CTRL_LOAD_HI 10
`define MTC_CTRL_DIR     11

// Status / mask bit positions
`define MTC_ST_OVERFLOW  0
`define MTC_ST_COMPARE   1

// Mode codes
`define MTC_MODE_STOP    2'b00
`define MTC_MODE_UP      2'b01
`define MTC_MODE_CONT    2'b10
`define MTC_MODE_UPDOWN  2'b11

// Length maxima
`define MTC_MAX_8        16'h00ff
`define MTC_MAX_10       16'h03ff
`define MTC_MAX_12       16'h0fff
`define MTC_MAX_16       16'hffff

// Reset values
`define MTC_CTRL_RESET   11'h000
`define MTC_PERIOD_RESET 16'h0000
`define MTC_MASK_RESET   2'b00

// AXI responses
`define MTC_RESP_OKAY    2'b00
`define MTC_RESP_SLVERR  2'b10

`endif

//--- rtl/mtc_clock_prescaler.v
`timescale 1ns/1ps
`include "mtc_defines.vh"

// Picks one of four timer clock inputs, detects its rising edge and divides
// by 1, 2, 4 or 8. Output is a one-cycle enable in the core_clk domain.
module mtc_clock_prescaler #(
    parameter DIV_WIDTH = 3
) (
    input  wire       core_clk,
    input  wire       rstn,
    input  wire       clearDivider,
    input  wire [1:0] clockSourceSelect,
    input  wire [1:0] inputDivider,
    input  wire       auxClock,
    input  wire       subMainClock,
    input  wire       externalTimerClock,
    input  wire       alternateInputClock,
    output reg        tickEn
);
    reg                 srcLevel;
    reg                 srcPrev_reg;
    reg [DIV_WIDTH-1:0] div_reg;
    reg [DIV_WIDTH-1:0] divMask;
    wire                srcRise;

    always @* begin
        case (clockSourceSelect) // RL6
            2'b00:   srcLevel = externalTimerClock;
            2'b01:   srcLevel = auxClock;
            2'b10:   srcLevel = subMainClock;
            default: srcLevel = alternateInputClock;
        endcase
        case (inputDivider) // RL7
            2'b00:   divMask = 3'h0;
            2'b01:   divMask = 3'h1;
            2'b10:   divMask = 3'h3;
            default: divMask = 3'h7;
        endcase
    end

    assign srcRise = srcLevel & ~srcPrev_reg;

    always @(posedge core_clk) begin
        if (!rstn) begin
            srcPrev_reg <= 1'b0;
            div_reg     <= {DIV_WIDTH{1'b0}};
            tickEn      <= 1'b0;
        end else begin
            srcPrev_reg <= srcLevel;
            tickEn      <= 1'b0;
            if (clearDivider) begin
                div_reg <= {DIV_WIDTH{1'b0}}; // RL2
            end else if (srcRise) begin
                if ((div_reg & divMask) == divMask) begin
                    div_reg <= {DIV_WIDTH{1'b0}};
                    tickEn  <= 1'b1;
                end else begin
                    div_reg <= div_reg + 3'h1;
                end
            end
        end
    end
endmodule // mtc_clock_prescaler

//--- rtl/mtc_timer_core.v
`timescale 1ns/1ps
`include "mtc_defines.vh"

// Operation
// RL1 - Count up or down on each divided tick
// RL2 - Clear zeroes count, divider and direction
// RL3 - Length select limits count to 8/10/12/16 bits
// RL4 - Count writes right-justified, upper bits zero
// RL5 - Count writes immediate, raise no flags
// RL6 - Source select picks one of four clocks
// RL7 - Divider passes by 1, 2, 4, 8
// RL8 - Mode field: stop, up, continuous, up/down
// RL9 - Zero period stops up modes; nonzero restarts
// RL10 - Up mode counts zero to period, wraps
// RL11 - Count above period in up mode restarts
// RL12 - Up mode: compare at period, overflow at wrap
// RL13 - Immediate period reload handles shrinking period
// RL14 - Continuous wraps at length maximum, overflow
// RL15 - Up/down counts to period and back
// RL16 - Period above maximum acts as continuous (done in up/down only; up mode counts past the length maximum up to period)
// RL17 - Direction kept across stop until clear
// RL18 - Up/down compare on reaching period, overflow down
// RL19 - Flags stay set until software clears
module mtc_timer_core (
    input  wire        core_clk,
    input  wire        rstn,
    input  wire        auxClock,
    input  wire        subMainClock,
    input  wire        externalTimerClock,
    input  wire        alternateInputClock,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg         irq
);
    reg  [10:0] ctrl_reg;
    reg  [15:0] countValue_reg;
    reg  [15:0] countValue_next;
    reg  [15:0] periodLatch_reg;
    reg         countDown_reg;
    reg         countDown_next;
    reg  [1:0]  status_reg;
    reg  [1:0]  mask_reg;
    reg         clearPulse_reg;
    reg         awHeld_reg;
    reg         wHeld_reg;
    reg  [7:0]  awAddr_reg;
    reg  [31:0] wData_reg;
    reg  [3:0]  wStrb_reg;
    reg  [1:0]  prevMode_reg;
    reg  [15:0] lengthMax;
    reg         overflowEvt;
    reg         compareEvt;
    reg  [15:0] wrWord;
    reg  [31:0] rdWord;
    reg         rdHit;
    wire        tickEn;
    wire [1:0]  modeControl;
    wire [1:0]  lengthSelect;
    wire [1:0]  latchLoadSelect;
    wire        wrFire;
    wire        wrHit;
    wire        wrCount;
    wire        wrPeriod;
    wire        running;
    wire        periodMode;
    wire        upPastPeriod;

    assign modeControl     = ctrl_reg[`MTC_CTRL_MODE_HI:`MTC_CTRL_MODE_LO];
    assign lengthSelect    = ctrl_reg[`MTC_CTRL_LEN_HI:`MTC_CTRL_LEN_LO];
    assign latchLoadSelect = ctrl_reg[`MTC_CTRL_LOAD_HI:`MTC_CTRL_LOAD_LO];

    mtc_clock_prescaler #(
        .DIV_WIDTH (3)
    ) u_prescaler (
        .core_clk            (core_clk),
        .rstn                (rstn),
        .clearDivider        (clearPulse_reg),
        .clockSourceSelect   (ctrl_reg[`MTC_CTRL_SRC_HI:`MTC_CTRL_SRC_LO]),
        .inputDivider        (ctrl_reg[`MTC_CTRL_DIV_HI:`MTC_CTRL_DIV_LO]),
        .auxClock            (auxClock),
        .subMainClock        (subMainClock),
        .externalTimerClock  (externalTimerClock),
        .alternateInputClock (alternateInputClock),
        .tickEn              (tickEn)
    );

    always @* begin
        case (lengthSelect) // RL3
            2'b00:   lengthMax = `MTC_MAX_16;
            2'b01:   lengthMax = `MTC_MAX_12;
            2'b10:   lengthMax = `MTC_MAX_10;
            default: lengthMax = `MTC_MAX_8;
        endcase
    end

    // AXI write side: address and data taken in either order, then one response
    assign wrFire   = awHeld_reg && wHeld_reg && !s_axi_bvalid;
    assign wrHit    = (awAddr_reg == `MTC_OFF_CTRL) || (awAddr_reg == `MTC_OFF_COUNT) ||
                      (awAddr_reg == `MTC_OFF_PERIOD) || (awAddr_reg == `MTC_OFF_STATUS) ||
                      (awAddr_reg == `MTC_OFF_MASK);
    assign wrCount  = wrFire && (awAddr_reg == `MTC_OFF_COUNT);
    assign wrPeriod = wrFire && (awAddr_reg == `MTC_OFF_PERIOD);

    always @* begin
        wrWord[7:0]  = wStrb_reg[0] ? wData_reg[7:0] : 8'h00;
        wrWord[15:8] = wStrb_reg[1] ? wData_reg[15:8] : 8'h00;
    end

    // Period latch only bounds the count in up and up/down modes
    assign periodMode   = (modeControl == `MTC_MODE_UP) || (modeControl == `MTC_MODE_UPDOWN);
    assign running      = (modeControl != `MTC_MODE_STOP) &&
                          !(periodMode && (periodLatch_reg == 16'h0000)); // RL8 RL9
    assign upPastPeriod = (modeControl == `MTC_MODE_UP) && (countValue_reg > periodLatch_reg);

    // Counter next-state. Events only come from ticks, never from writes.
    always @* begin
        countValue_next = countValue_reg;
        countDown_next  = countDown_reg;
        overflowEvt     = 1'b0;
        compareEvt      = 1'b0;
        if (clearPulse_reg) begin
            countValue_next = 16'h0000; // RL2
            countDown_next  = 1'b0;
        end else if (wrCount) begin
            countValue_next = wrWord & lengthMax; // RL4 RL5
        end else if (periodMode && (periodLatch_reg == 16'h0000)) begin
            countValue_next = 16'h0000; // RL9
            countDown_next  = 1'b0;
        end else if (upPastPeriod && (prevMode_reg != `MTC_MODE_UP)) begin
            countValue_next = 16'h0000; // RL11
        end else if (running && tickEn) begin // RL1
            case (modeControl)
                `MTC_MODE_UP: begin
                    // A period set below the count rolls over on this tick
                    if (countValue_reg >= periodLatch_reg) begin // RL10 RL13
                        countValue_next = 16'h0000;
                        overflowEvt     = 1'b1; // RL12
                    end else begin
                        countValue_next = countValue_reg + 16'h0001;
                        compareEvt      = (countValue_next == periodLatch_reg); // RL12
                    end
                end
                `MTC_MODE_CONT: begin
                    if (countValue_reg >= lengthMax) begin // RL14
                        countValue_next = 16'h0000;
                        overflowEvt     = 1'b1;
                    end else begin
                        countValue_next = countValue_reg + 16'h0001;
                    end
                    compareEvt = (countValue_next == periodLatch_reg);
                end
                `MTC_MODE_UPDOWN: begin
                    if (periodLatch_reg > lengthMax) begin // RL16
                        countDown_next = 1'b0;
                        if (countValue_reg >= lengthMax) begin
                            countValue_next = 16'h0000;
                            overflowEvt     = 1'b1;
                        end else begin
                            countValue_next = countValue_reg + 16'h0001;
                        end
                    end else if (countDown_reg) begin // RL15 RL17
                        if (countValue_reg <= 16'h0001) begin
                            countValue_next = 16'h0000;
                            countDown_next  = 1'b0;
                            overflowEvt     = (countValue_reg == 16'h0001); // RL18
                        end else begin
                            countValue_next = countValue_reg - 16'h0001;
                        end
                    end else if (countValue_reg >= periodLatch_reg) begin
                        // New period below count: turn and head down
                        countDown_next  = 1'b1; // RL13
                        countValue_next = countValue_reg - 16'h0001;
                    end else begin
                        countValue_next = countValue_reg + 16'h0001;
                        compareEvt      = (countValue_next == periodLatch_reg); // RL18
                        countDown_next  = compareEvt;
                    end
                end
                default: begin
                    countValue_next = countValue_reg;
                end
            endcase
        end
    end

    always @(posedge core_clk) begin
        if (!rstn) begin
            ctrl_reg        <= `MTC_CTRL_RESET;
            countValue_reg  <= 16'h0000;
            periodLatch_reg <= `MTC_PERIOD_RESET;
            countDown_reg   <= 1'b0;
            status_reg      <= 2'b00;
            mask_reg        <= `MTC_MASK_RESET;
            clearPulse_reg  <= 1'b0;
            prevMode_reg    <= `MTC_MODE_STOP;
            irq             <= 1'b0;
        end else begin
            countValue_reg <= countValue_next;
            countDown_reg  <= countDown_next;
            prevMode_reg   <= modeControl;
            clearPulse_reg <= 1'b0;
            irq            <= |(status_reg & mask_reg);
            // Set wins over a simultaneous write-one-to-clear
            status_reg[`MTC_ST_OVERFLOW] <= overflowEvt | (status_reg[`MTC_ST_OVERFLOW] &
                ~(wrFire && awAddr_reg == `MTC_OFF_STATUS && wStrb_reg[0] &&
                  wData_reg[`MTC_ST_OVERFLOW])); // RL19
            status_reg[`MTC_ST_COMPARE]  <= compareEvt | (status_reg[`MTC_ST_COMPARE] &
                ~(wrFire && awAddr_reg == `MTC_OFF_STATUS && wStrb_reg[0] &&
                  wData_reg[`MTC_ST_COMPARE])); // RL19
            if (wrFire && (awAddr_reg == `MTC_OFF_CTRL)) begin
                if (wStrb_reg[0]) begin
                    ctrl_reg[7:1] <= wData_reg[7:1];
                    // Clear acts as a self-resetting strobe
                    clearPulse_reg <= wData_reg[`MTC_CTRL_CLEAR]; // RL2
                end
                if (wStrb_reg[1]) begin
                    ctrl_reg[10:8] <= wData_reg[10:8];
                end
            end
            if (wrPeriod) begin
                // Only the immediate load event is modelled
                periodLatch_reg <= wrWord; // RL13
            end
            if (wrFire && (awAddr_reg == `MTC_OFF_MASK) && wStrb_reg[0]) begin
                mask_reg <= wData_reg[1:0];
            end
        end
    end

    always @(posedge core_clk) begin
        if (!rstn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `MTC_RESP_OKAY;
            awHeld_reg    <= 1'b0;
            wHeld_reg     <= 1'b0;
            awAddr_reg    <= 8'h00;
            wData_reg     <= 32'h00000000;
            wStrb_reg     <= 4'h0;
        end else begin
            s_axi_awready <= !awHeld_reg && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready  <= !wHeld_reg && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_reg    <= 1'b1;
                awAddr_reg    <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_reg    <= 1'b1;
                wData_reg    <= s_axi_wdata;
                wStrb_reg    <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wrFire) begin
                awHeld_reg   <= 1'b0;
                wHeld_reg    <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wrHit ? `MTC_RESP_OKAY : `MTC_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always @* begin
        rdHit  = 1'b1;
        rdWord = 32'h00000000;
        case (s_axi_araddr)
            `MTC_OFF_CTRL:   rdWord = {20'h00000, countDown_reg, ctrl_reg[10:1], 1'b0};
            `MTC_OFF_COUNT:  rdWord = {16'h0000, countValue_reg};
            `MTC_OFF_PERIOD: rdWord = {16'h0000, periodLatch_reg};
            `MTC_OFF_STATUS: rdWord = {30'h00000000, status_reg};
            `MTC_OFF_MASK:   rdWord = {30'h00000000, mask_reg};
            default:         rdHit  = 1'b0;
        endcase
    end

    always @(posedge core_clk) begin
        if (!rstn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `MTC_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rdWord;
                s_axi_rresp  <= rdHit ? `MTC_RESP_OKAY : `MTC_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // mtc_timer_core

//--- tb/mtc_timer_core_asserts.sv
`timescale 1ns/1ps
module mtc_timer_core_asserts (
    input wire        core_clk,
    input wire        rstn,
    input wire [7:0]  s_axi_awaddr,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire [7:0]  s_axi_araddr,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    input wire        irq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence

    // Both halves are held one cycle before the response is raised
    property p_wr_answer; s_wr_take |-> ##2 s_axi_bvalid; endproperty
    property p_wr_err;
        s_wr_take ##0 (s_axi_awaddr >= 8'h20) |-> ##2 s_axi_bvalid && s_axi_bresp == 2'b10;
    endproperty
    property p_rd_answer; s_rd_take |=> s_axi_rvalid; endproperty
    property p_rd_err;
        s_rd_take ##0 (s_axi_araddr >= 8'h20) |=> s_axi_rvalid && s_axi_rresp == 2'b10;
    endproperty
    property p_rd_count;
        s_rd_take ##0 (s_axi_araddr == 8'h04) |=> s_axi_rresp == 2'b00 && !(|s_axi_rdata[31:16]);
    endproperty
    property p_clear_reads0;
        s_rd_take ##0 (s_axi_araddr == 8'h00) |=> !s_axi_rdata[0] && !(|s_axi_rdata[31:12]);
    endproperty
    property p_wr_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    property p_rd_busy; s_axi_rvalid |-> !s_axi_arready; endproperty
    // Flags only drop through software, so irq may only fall just after a write
    property p_irq_fall;
        $fell(irq) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2) || $past(s_axi_bvalid, 3);
    endproperty

    a_wr_answer: assert property (p_wr_answer) else $error("no write response");
    a_wr_err: assert property (p_wr_err) else $error("unmapped write not refused");
    a_rd_answer: assert property (p_rd_answer) else $error("no read response");
    a_rd_err: assert property (p_rd_err) else $error("unmapped read not refused");
    a_rd_count: assert property (p_rd_count) else $error("count upper bits set");
    a_clear_reads0: assert property (p_clear_reads0) else $error("clear bit reads one");
    a_wr_busy: assert property (p_wr_busy) else $error("write ready while busy");
    a_rd_busy: assert property (p_rd_busy) else $error("read ready while busy");
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell without write");
endmodule // mtc_timer_core_asserts

bind mtc_timer_core mtc_timer_core_asserts u_chk (
    .core_clk(core_clk), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .irq(irq)
);

//--- tb/mtc_testbench.sv
`timescale 1ns/1ps
`include "mtc_defines.vh"
module testbench;
    logic        core_clk = 0;
    logic        rstn = 0;
    logic [3:0]  srcClk = 0;
    logic [1:0]  sel = 0;
    logic [7:0]  awAddr = 0;
    logic [7:0]  arAddr = 0;
    logic [31:0] wData = 0;
    logic [31:0] rdV;
    logic [1:0]  respV;
    logic        awValid = 0;
    logic        wValid = 0;
    logic        bReady = 0;
    logic        arValid = 0;
    logic        rReady = 0;
    wire         awReady, wReady, bValid, arReady, rValid, irq;
    wire  [1:0]  bResp, rResp;
    wire  [31:0] rData;
    int          mismatches = 0;
    int          compares = 0;

    always #2.5 core_clk = ~core_clk;

    mtc_timer_core DUT (
        .core_clk(core_clk), .rstn(rstn),
        .auxClock(srcClk[1]), .subMainClock(srcClk[2]),
        .externalTimerClock(srcClk[0]), .alternateInputClock(srcClk[3]),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_wdata(wData), .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid),
        .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
        .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
        .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
        .s_axi_rvalid(rValid), .s_axi_rready(rReady), .irq(irq)
    );

    task cmp(input [31:0] got, input [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Waits as long as the slave needs; only the watchdog ends a hang
    task wr(input [7:0] a, input [31:0] d);
        @(posedge core_clk);
        awAddr <= a;
        wData <= d;
        awValid <= 1;
        wValid <= 1;
        bReady <= 1;
        do begin
            @(posedge core_clk);
            if (awReady) awValid <= 0;
            if (wReady) wValid <= 0;
        end while (!bValid);
        bReady <= 0;
        respV = bResp;
    endtask

    task rd(input [7:0] a);
        @(posedge core_clk);
        arAddr <= a;
        arValid <= 1;
        rReady <= 1;
        do begin
            @(posedge core_clk);
            if (arReady) arValid <= 0;
        end while (!rValid);
        rReady <= 0;
        rdV = rData;
        respV = rResp;
    endtask

    task rc(input [7:0] a, input [31:0] e);
        rd(a);
        cmp(rdV, e);
    endtask

    // Source rises spaced well apart so every rise is seen as one edge
    task tk(input int n);
        repeat (n) begin
            srcClk[sel] <= 1;
            repeat (3) @(posedge core_clk);
            srcClk[sel] <= 0;
            repeat (3) @(posedge core_clk);
        end
        repeat (4) @(posedge core_clk);
    endtask

    function [31:0] cf(input [1:0] m, input [1:0] d, input [1:0] l);
        cf = {23'h0, l, sel, d, m, 1'b0};
    endfunction

    task t_reset;
        rc(`MTC_OFF_CTRL, 0);
        rc(`MTC_OFF_COUNT, 0);
        rc(`MTC_OFF_PERIOD, 0);
        rc(`MTC_OFF_STATUS, 0);
        rc(`MTC_OFF_MASK, 0);
        rd(8'h20);
        cmp({30'h0, respV}, `MTC_RESP_SLVERR);
        wr(8'h24, 1);
        cmp({30'h0, respV}, `MTC_RESP_SLVERR);
        $display("reset test done");
    endtask

    task t_up;
        wr(`MTC_OFF_MASK, 3);
        wr(`MTC_OFF_PERIOD, 3);
        wr(`MTC_OFF_CTRL, cf(`MTC_MODE_UP, 0, 0));
        wr(`MTC_OFF_COUNT, 3);
        rc(`MTC_OFF_STATUS, 0);
        wr(`MTC_OFF_COUNT, 0);
        tk(3);
        rc(`MTC_OFF_COUNT, 3);
        rc(`MTC_OFF_STATUS, 2);
        tk(1);
        rc(`MTC_OFF_COUNT, 0);
        rc(`MTC_OFF_STATUS, 3);
        cmp({31'h0, irq}, 1);
        tk(5);
        rc(`MTC_OFF_STATUS, 3);
        wr(`MTC_OFF_STATUS, 1);
        cmp({30'h0, respV}, `MTC_RESP_OKAY);
        rc(`MTC_OFF_STATUS, 2);
        wr(`MTC_OFF_MASK, 1);
        rc(`MTC_OFF_MASK, 1);
        cmp({31'h0, irq}, 0);
        wr(`MTC_OFF_STATUS, 3);
        $display("up test done");
    endtask

    task t_div;
        for (int s = 0; s < 4; s++) begin
            for (int d = 0; d < 4; d++) begin
                sel = 2'(s);
                wr(`MTC_OFF_CTRL, cf(`MTC_MODE_STOP, 0, 0) | 1);
                wr(`MTC_OFF_CTRL, cf(`MTC_MODE_CONT, 2'(d), 0));
                sel = 2'(s + 1);
                tk(8);
                sel = 2'(s);
                rc(`MTC_OFF_COUNT, 0);
                tk(8);
                rc(`MTC_OFF_COUNT, 8 >> d);
            end
        end
        $display("divider test done");
    endtask

    task t_len;
        sel = 0;
        for (int l = 0; l < 4; l++) begin
            wr(`MTC_OFF_CTRL, cf(`MTC_MODE_STOP, 0, 2'(l)));
            wr(`MTC_OFF_STATUS, 3);
            wr(`MTC_OFF_COUNT, 32'hffff);
            rc(`MTC_OFF_COUNT, 32'hffff >> (l ? 2 * l + 2 : 0));
            wr(`MTC_OFF_CTRL, cf(`MTC_MODE_CONT, 0, 2'(l)));
            tk(1);
            rc(`MTC_OFF_COUNT, 0);
            rc(`MTC_OFF_STATUS, 1);
        end
        $display("length test done");
    endtask

    task t_period;
        wr(`MTC_OFF_CTRL, cf(`MTC_MODE_STOP, 0, 0));
        wr(`MTC_OFF_PERIOD, 4);
        wr(`MTC_OFF_COUNT, 9);
        wr(`MTC_OFF_CTRL, cf(`MTC_MODE_UP, 0, 0));
        rc(`MTC_OFF_COUNT, 0);
        tk(2);
        wr(`MTC_OFF_PERIOD, 0);
        tk(2);
        rc(`MTC_OFF_COUNT, 0);
        wr(`MTC_OFF_PERIOD, 10);
        tk(6);
        rc(`MTC_OFF_COUNT, 6);
        wr(`MTC_OFF_PERIOD, 3);
        tk(2);
        rd(`MTC_OFF_COUNT);
        cmp({31'h0, rdV <= 32'h1}, 1);
        $display("period test done");
    endtask

    task t_updown;
        wr(`MTC_OFF_CTRL, cf(`MTC_MODE_STOP, 0, 0) | 1);
        wr(`MTC_OFF_PERIOD, 3);
        wr(`MTC_OFF_STATUS, 3);
        wr(`MTC_OFF_CTRL, cf(`MTC_MODE_UPDOWN, 0, 0));
        tk(3);
        rc(`MTC_OFF_COUNT, 3);
        rc(`MTC_OFF_STATUS, 2);
        tk(2);
        rc(`MTC_OFF_COUNT, 1);
        wr(`MTC_OFF_CTRL, cf(`MTC_MODE_STOP, 0, 0));
        rc(`MTC_OFF_CTRL, 32'h800);
        tk(2);
        rc(`MTC_OFF_COUNT, 1);
        wr(`MTC_OFF_CTRL, cf(`MTC_MODE_UPDOWN, 0, 0));
        tk(1);
        rc(`MTC_OFF_COUNT, 0);
        rc(`MTC_OFF_STATUS, 3);
        tk(4);
        wr(`MTC_OFF_CTRL, cf(`MTC_MODE_UPDOWN, 0, 0) | 1);
        rc(`MTC_OFF_CTRL, 32'h6);
        rc(`MTC_OFF_COUNT, 0);
        tk(1);
        rc(`MTC_OFF_COUNT, 1);
        wr(`MTC_OFF_CTRL, cf(`MTC_MODE_STOP, 0, 3));
        wr(`MTC_OFF_PERIOD, 32'h1ff);
        wr(`MTC_OFF_COUNT, 32'hfe);
        wr(`MTC_OFF_CTRL, cf(`MTC_MODE_UPDOWN, 0, 3));
        tk(2);
        rc(`MTC_OFF_COUNT, 0);
        $display("updown test done");
    endtask

    task complete_run;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge core_clk);
        rstn <= 1;
        t_reset;
        t_up;
        t_div;
        t_len;
        t_period;
        t_updown;
        complete_run;
    end

    // Whole run is a few thousand cycles; this allows ample margin
    initial begin
        #100000;
        mismatches++;
        complete_run;
    end
endmodule // testbench
